// File: bench/pacl_port_regs_bench.sv
// Self-checking bench of the per-port register bank.
// Assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/1ps
`include "pacl_params.svh"

module pacl_port_regs_bench
	import pacl_pkg::*;
;
	// Port under test and its register addresses
	localparam logic [3:0]  PN    = 4'h1;
	localparam logic [15:0] A_CTL = {PN, `PACL_OFS_ACL_CTRL};
	localparam logic [15:0] A_MIR = {PN, `PACL_OFS_MIRROR};
	localparam logic [15:0] A_PRI = {PN, `PACL_OFS_PRIO};
	// Every source valid, results 5,2,3,4,1; none valid; DSCP and ACL only
	localparam pacl_cls_t   CA = {5'h1f, 3'd5, 3'd2, 3'd3, 3'd4, 3'd1};
	localparam pacl_cls_t   CN = {5'h00, 3'd5, 3'd2, 3'd3, 3'd4, 3'd1};
	localparam pacl_cls_t   CP = {5'h03, 3'd5, 3'd2, 3'd3, 3'd4, 3'd1};
	// Design ports
	logic          clk_i, rst_n_i, reg_wr_i, reg_rd_i, tbl_done_i;
	logic [15:0]   reg_addr_i;
	logic [7:0]    reg_wdata_i, reg_rdata_o;
	logic          reg_rvld_o, cls_vld_i, prio_vld_o, prio_hit_o;
	pacl_tbl_req_t tbl_req_o;
	logic          rx_frame_i, tx_frame_i, mon_frame_i;
	logic          rx_mon_o, tx_mon_o, mon_tx_o;
	logic          rx_sniff_o, tx_sniff_o, sniffer_o;
	pacl_cls_t     cls_i;
	logic [2:0]    dflt_prio_i, prio_o;
	// Counters
	int            n_mismatch = 0, n_tests = 0, cyc = 0;

	pacl_port_regs #(.PORT_NUM(PN)) pacl_port_regs_inst (.*);

	// 100 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// Cut a hang short
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	// Counts and verdict, then stop
	task automatic give_verdict;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Compare one byte
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// One-cycle register write in this port's space
	task automatic wr(input logic [11:0] ofs, input logic [7:0] d);
		@(negedge clk_i);
		reg_wr_i = 1'b1;
		reg_addr_i = {PN, ofs};
		reg_wdata_i = d;
		@(negedge clk_i);
		reg_wr_i = 1'b0;
	endtask

	// One-cycle read, answer checked one cycle later
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(negedge clk_i);
		reg_rd_i = 1'b1;
		reg_addr_i = a;
		@(negedge clk_i);
		reg_rd_i = 1'b0;
		check({7'h00, reg_rvld_o}, 8'h01);
		check(reg_rdata_o, exp);
	endtask

	// Completion pulse from the table engine
	task automatic done_pulse;
		@(negedge clk_i);
		tbl_done_i = 1'b1;
		@(negedge clk_i);
		tbl_done_i = 1'b0;
	endtask

	// Reset values, read-only bits, unmapped and foreign addresses
	task automatic t_regs;
		rd(A_CTL, `PACL_RST_ACL_CTRL);
		rd(A_MIR, `PACL_RST_MIRROR);
		rd(A_PRI, `PACL_RST_PRIO);
		wr(`PACL_OFS_ACL_CTRL, 8'hff);
		wr(`PACL_OFS_MIRROR, 8'hff);
		wr(`PACL_OFS_PRIO, 8'hff);
		rd(A_CTL, 8'h7f);
		rd(A_MIR, 8'h62);
		rd(A_PRI, 8'hdf);
		rd({PN, 12'h700}, 8'h00);
		rd({PN + 4'h1, `PACL_OFS_PRIO}, 8'h00);
	endtask

	// Table access: stray done, start, busy refusal, completion
	task automatic t_tbl(input logic dir, input logic [3:0] idx, input int dly);
		wr(`PACL_OFS_ACL_CTRL, {3'b000, dir, idx});
		done_pulse();
		rd(A_CTL, {3'b011, dir, idx});
		wr(`PACL_OFS_BE_LSB, 8'hff);
		check({2'b00, tbl_req_o}, {3'b001, dir, idx});
		rd(A_CTL, {1'b0, ~dir, dir, dir, idx});
		wr(`PACL_OFS_BE_LSB, 8'hff);
		check({7'h00, tbl_req_o.go}, 8'h00);
		repeat (dly) @(negedge clk_i);
		rd(A_CTL, {1'b0, ~dir, dir, dir, idx});
		done_pulse();
		rd(A_CTL, {3'b011, dir, idx});
	endtask

	// Mirroring roles against frame events; switch-wide mirroring
	// control lives outside this block and is taken as configured
	task automatic t_frames(input logic [7:0] m);
		wr(`PACL_OFS_MIRROR, m);
		@(negedge clk_i);
		rx_frame_i = 1'b1;
		tx_frame_i = 1'b1;
		mon_frame_i = 1'b1;
		@(negedge clk_i);
		{rx_frame_i, tx_frame_i, mon_frame_i} = 3'b000;
		check({5'h00, rx_mon_o, tx_mon_o, mon_tx_o}, {5'h00, m[6], m[5], m[1]});
		check({5'h00, rx_sniff_o, tx_sniff_o, sniffer_o}, {5'h00, m[6], m[5], m[1]});
	endtask

	// One classified frame under a given priority control
	task automatic t_prio(input logic [7:0] ctl, input pacl_cls_t c,
		input logic [2:0] exp, input logic hit);
		wr(`PACL_OFS_PRIO, ctl);
		@(negedge clk_i);
		cls_vld_i = 1'b1;
		cls_i = c;
		@(negedge clk_i);
		cls_vld_i = 1'b0;
		check({4'h0, prio_vld_o, prio_o}, {5'h01, exp});
		check({7'h00, prio_hit_o}, {7'h00, hit});
	endtask

	// Main sequence
	initial begin
		{reg_wr_i, reg_rd_i, tbl_done_i, cls_vld_i} = 4'h0;
		{rx_frame_i, tx_frame_i, mon_frame_i} = 3'h0;
		reg_addr_i = 16'h0000;
		reg_wdata_i = 8'h00;
		cls_i = '0;
		dflt_prio_i = 3'h6;
		rst_n_i = 1'b0;
		repeat (20) @(negedge clk_i);
		rst_n_i = 1'b1;
		t_regs();
		t_tbl(1'b1, 4'hf, 6);
		t_tbl(1'b0, 4'h0, 0);
		t_frames(8'h40);
		t_frames(8'h22);
		t_frames(8'h00);
		t_prio(8'h9f, CA, 3'd5, 1'b1);
		t_prio(8'hdf, CA, 3'd5, 1'b1);
		t_prio(8'h9f, CP, 3'd4, 1'b1);
		t_prio(8'h5f, CA, 3'd7, 1'b1);
		t_prio(8'h49, CA, 3'd3, 1'b1);
		t_prio(8'h1f, CA, 3'd1, 1'b1);
		t_prio(8'h10, CA, 3'd5, 1'b1);
		t_prio(8'h08, CA, 3'd2, 1'b1);
		t_prio(8'h04, CA, 3'd3, 1'b1);
		t_prio(8'h02, CA, 3'd4, 1'b1);
		t_prio(8'h01, CA, 3'd1, 1'b1);
		t_prio(8'h00, CA, 3'd6, 1'b0);
		t_prio(8'h1f, CN, 3'd6, 1'b0);
		give_verdict();
	end
endmodule

// File: bench/pacl_port_regs_props.sv
// Checker of the per-port register bank, watching its ports only.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`include "pacl_params.svh"

module pacl_port_regs_props
	import pacl_pkg::*;
#(
	parameter logic [3:0] PORT_NUM = 4'h1  // Upper address nibble
)
(
	// Clock, reset and register bus
	input  wire logic          clk_i,
	input  wire logic          rst_n_i,
	input  wire logic          reg_wr_i,
	input  wire logic          reg_rd_i,
	input  wire logic [15:0]   reg_addr_i,
	input  wire logic          reg_rvld_o,
	// Table request and frame events
	input  wire pacl_tbl_req_t tbl_req_o,
	input  wire logic          rx_frame_i,
	input  wire logic          tx_frame_i,
	input  wire logic          mon_frame_i,
	input  wire logic          rx_mon_o,
	input  wire logic          tx_mon_o,
	input  wire logic          mon_tx_o,
	input  wire logic          rx_sniff_o,
	input  wire logic          tx_sniff_o,
	input  wire logic          sniffer_o,
	// Priority resolution
	input  wire logic          cls_vld_i,
	input  wire logic [2:0]    dflt_prio_i,
	input  wire logic [2:0]    prio_o,
	input  wire logic          prio_vld_o,
	input  wire logic          prio_hit_o
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// Start pulse that drops after one cycle
	sequence s_go_once;
		tbl_req_o.go ##1 !tbl_req_o.go;
	endsequence

	AST_GO_ONCE: assert property (tbl_req_o.go |-> s_go_once)
		else $error("table start pulse too long");
	AST_GO_CAUSE: assert property (tbl_req_o.go |-> $past(reg_wr_i) &&
		$past(reg_addr_i) == {PORT_NUM, `PACL_OFS_BE_LSB})
		else $error("table start without trigger write");
	AST_RD_ANS: assert property (reg_rvld_o == $past(reg_rd_i))
		else $error("read answer not one cycle after strobe");
	AST_RX_MON: assert property (rx_mon_o == $past(rx_frame_i && rx_sniff_o))
		else $error("receive mark wrong");
	AST_TX_MON: assert property (tx_mon_o == $past(tx_frame_i && tx_sniff_o))
		else $error("transmit mark wrong");
	AST_MON_TX: assert property (mon_tx_o == $past(mon_frame_i && sniffer_o))
		else $error("sniffer copy wrong");
	AST_PRIO_VLD: assert property (prio_vld_o == $past(cls_vld_i))
		else $error("priority valid not one cycle after input");
	AST_PRIO_HOLD: assert property (!prio_vld_o |-> $stable(prio_o))
		else $error("priority changed without new result");
	AST_PRIO_DFLT: assert property (prio_vld_o && !prio_hit_o |->
		prio_o == $past(dflt_prio_i))
		else $error("default priority not used");
endmodule

bind pacl_port_regs pacl_port_regs_props #(.PORT_NUM(PORT_NUM))
	pacl_port_regs_props_inst (.*);

// File: logic/pacl_params.svh
// Constants of the per-port ACL access, mirroring and priority registers.
// Assumes one register space per port, port number in address [15:12].
`ifndef PACL_PARAMS_SVH
`define PACL_PARAMS_SVH

// Register offsets inside one port's space
`define PACL_OFS_BE_LSB      12'h611
`define PACL_OFS_ACL_CTRL    12'h612
`define PACL_OFS_MIRROR      12'h800
`define PACL_OFS_PRIO        12'h801

// Access trigger and tracking fields
`define PACL_BIT_WR_STAT     6
`define PACL_BIT_RD_STAT     5
`define PACL_BIT_DIR         4
`define PACL_IDX_MSB         3

// Mirroring fields
`define PACL_BIT_RX_SNIFF    6
`define PACL_BIT_TX_SNIFF    5
`define PACL_BIT_SNIFFER     1

// Priority classification fields
`define PACL_BIT_HIGHEST     7
`define PACL_BIT_ORED        6
`define PACL_BIT_MAC_EN      4
`define PACL_BIT_VLAN_EN     3
`define PACL_BIT_PCP_EN      2
`define PACL_BIT_DSCP_EN     1
`define PACL_BIT_ACL_EN      0

// Writable bit masks
`define PACL_MASK_ACL_CTRL   8'h1f
`define PACL_MASK_MIRROR     8'h62
`define PACL_MASK_PRIO       8'hdf

// Reset values
`define PACL_RST_ACL_CTRL    8'h60
`define PACL_RST_MIRROR      8'h00
`define PACL_RST_PRIO        8'h00
`define PACL_RST_PRIO_OUT    3'h0

`endif

// File: logic/pacl_pkg.sv
// Types shared by the per-port register bank and its priority resolver.
// Assumes the constants header is included by each design file.
package pacl_pkg;

	// Table access sequencer states, one-hot
	typedef enum logic [1:0] {
		PACL_IDLE = 2'b01,
		PACL_BUSY = 2'b10
	} pacl_state_t;

	// Classification results of one ingress frame
	typedef struct packed {
		logic [4:0] vld;   // Per source: 4 MAC, 3 VLAN, 2 PCP, 1 DSCP, 0 ACL
		logic [2:0] mac;   // MAC address result
		logic [2:0] vlan;  // VLAN result
		logic [2:0] pcp;   // Tag priority result
		logic [2:0] dscp;  // DiffServ result
		logic [2:0] acl;   // Access list result
	} pacl_cls_t;

	// Request to the access-list table engine
	typedef struct packed {
		logic       go;    // One-cycle start pulse
		logic       wr;    // 1 write, 0 read
		logic [3:0] idx;   // Entry index
	} pacl_tbl_req_t;

endpackage

// File: logic/pacl_port_regs.sv
// Per-port access-list trigger, mirroring and priority control registers.
// Assumes a same-clock management register port and a table engine that
// answers each request with one done pulse.
`timescale 1ns/1ps
`include "pacl_params.svh"

// Behaviour
// - Write status low until table write completes
// - Read status low until read completes
// - Receive sniff marks and mirrors received frames
// - Transmit sniff marks and mirrors sent frames
// - Sniffer bit makes port send monitored frames
// - Highest bit picks largest enabled result
// - OR bit combines all enabled results when highest bit is clear
// - Bit 4 enables MAC address classification
// - Bit 3 enables VLAN classification
// - Bit 2 enables tag priority classification
// - Bit 1 enables DiffServ classification
// - Bit 0 enables access list classification
// - Low byte-enable write starts table access
module pacl_port_regs
	import pacl_pkg::*;
#(
	parameter logic [3:0] PORT_NUM = 4'h1  // Upper address nibble
)
(
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_n_i,
	// Management register port
	input  wire logic          reg_wr_i,
	input  wire logic          reg_rd_i,
	input  wire logic [15:0]   reg_addr_i,
	input  wire logic [7:0]    reg_wdata_i,
	output logic      [7:0]    reg_rdata_o,
	output logic               reg_rvld_o,
	// Access-list table engine
	output pacl_tbl_req_t      tbl_req_o,
	input  wire logic          tbl_done_i,
	// Frame events of this port
	input  wire logic          rx_frame_i,
	input  wire logic          tx_frame_i,
	input  wire logic          mon_frame_i,
	output logic               rx_mon_o,
	output logic               tx_mon_o,
	output logic               mon_tx_o,
	// Mirroring roles as levels
	output logic               rx_sniff_o,
	output logic               tx_sniff_o,
	output logic               sniffer_o,
	// Ingress priority classification
	input  wire logic          cls_vld_i,
	input  wire pacl_cls_t     cls_i,
	input  wire logic [2:0]    dflt_prio_i,
	output logic      [2:0]    prio_o,
	output logic               prio_vld_o,
	output logic               prio_hit_o
);

	// Control registers and their next values
	logic [7:0]    acl_access_trigger_ctrl_q;  // Status, direction, index
	logic [7:0]    acl_access_trigger_ctrl_d;
	logic [7:0]    port_mirror_ctrl_q;         // Sniff roles
	logic [7:0]    port_mirror_ctrl_d;
	logic [7:0]    port_prio_class_ctrl_q;     // Sources and combining
	logic [7:0]    port_prio_class_ctrl_d;
	pacl_state_t   state_q;                    // Table access sequencer
	pacl_state_t   state_d;
	pacl_tbl_req_t tbl_req_q;                  // Request to table engine
	pacl_tbl_req_t tbl_req_d;

	// Read answer
	logic [7:0]    rdata_q;
	logic [7:0]    rdata_d;
	logic          rvld_q;
	logic          rvld_d;

	// Frame marks and priority result
	logic          rx_mon_q;
	logic          rx_mon_d;
	logic          tx_mon_q;
	logic          tx_mon_d;
	logic          mon_tx_q;
	logic          mon_tx_d;
	logic [2:0]    prio_q;
	logic [2:0]    prio_d;
	logic          prio_vld_q;
	logic          prio_vld_d;
	logic          prio_hit_q;
	logic          prio_hit_d;

	// Decode helpers
	logic          port_hit;     // Address falls in this port's space
	logic [11:0]   ofs;          // Offset inside the port space
	logic          trig;         // Table access start this cycle
	logic [2:0]    res_prio;     // Resolver output
	logic          res_hit;      // Resolver found an enabled source

	assign port_hit = (reg_addr_i[15:12] == PORT_NUM);
	assign ofs      = reg_addr_i[11:0];

	// Start an access on a write of the low byte-enable register
	assign trig = reg_wr_i && port_hit && (ofs == `PACL_OFS_BE_LSB)
		&& (state_q == PACL_IDLE);

	// Priority resolver
	pacl_prio_resolve u_resolve (
		.ctrl_i (port_prio_class_ctrl_q),
		.cls_i  (cls_i),
		.dflt_i (dflt_prio_i),
		.prio_o (res_prio),
		.hit_o  (res_hit)
	);

	// Next values of registers, status bits and sequencer
	always_comb begin
		acl_access_trigger_ctrl_d = acl_access_trigger_ctrl_q;
		port_mirror_ctrl_d        = port_mirror_ctrl_q;
		port_prio_class_ctrl_d    = port_prio_class_ctrl_q;
		state_d                   = state_q;
		tbl_req_d                 = '0;
		// Software writes touch only writable bits
		if (reg_wr_i && port_hit) begin
			unique case (ofs)
				`PACL_OFS_ACL_CTRL: begin
					acl_access_trigger_ctrl_d =
						(acl_access_trigger_ctrl_q & ~`PACL_MASK_ACL_CTRL)
						| (reg_wdata_i & `PACL_MASK_ACL_CTRL);
				end
				`PACL_OFS_MIRROR: begin
					port_mirror_ctrl_d =
						reg_wdata_i & `PACL_MASK_MIRROR;
				end
				`PACL_OFS_PRIO: begin
					port_prio_class_ctrl_d =
						reg_wdata_i & `PACL_MASK_PRIO;
				end
				default: begin
					// Other offsets belong to neighbouring blocks
				end
			endcase
		end
		unique case (state_q)
			PACL_IDLE: begin
				// Launch request, clear the matching status
				if (trig) begin
					tbl_req_d.go  = 1'b1;
					tbl_req_d.wr  =
						acl_access_trigger_ctrl_q[`PACL_BIT_DIR];
					tbl_req_d.idx =
						acl_access_trigger_ctrl_q[`PACL_IDX_MSB:0];
					if (acl_access_trigger_ctrl_q[`PACL_BIT_DIR]) begin
						acl_access_trigger_ctrl_d[`PACL_BIT_WR_STAT] =
							1'b0;
					end else begin
						acl_access_trigger_ctrl_d[`PACL_BIT_RD_STAT] =
							1'b0;
					end
					state_d = PACL_BUSY;
				end
			end
			PACL_BUSY: begin
				// Completion sets both status bits back to done
				if (tbl_done_i) begin
					acl_access_trigger_ctrl_d[`PACL_BIT_WR_STAT] =
						1'b1;
					acl_access_trigger_ctrl_d[`PACL_BIT_RD_STAT] =
						1'b1;
					state_d = PACL_IDLE;
				end
			end
			default: begin
				// Illegal code: recover to idle
				state_d = PACL_IDLE;
			end
		endcase
	end

	// Register bank and sequencer flip-flops
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acl_access_trigger_ctrl_q <= `PACL_RST_ACL_CTRL;
			port_mirror_ctrl_q        <= `PACL_RST_MIRROR;
			port_prio_class_ctrl_q    <= `PACL_RST_PRIO;
			state_q                   <= PACL_IDLE;
			tbl_req_q                 <= '0;
		end else begin
			acl_access_trigger_ctrl_q <= acl_access_trigger_ctrl_d;
			port_mirror_ctrl_q        <= port_mirror_ctrl_d;
			port_prio_class_ctrl_q    <= port_prio_class_ctrl_d;
			state_q                   <= state_d;
			tbl_req_q                 <= tbl_req_d;
		end
	end

	// Read mux; unmapped offsets and other ports answer zero
	always_comb begin
		rdata_d = rdata_q;
		rvld_d  = 1'b0;
		if (reg_rd_i) begin
			rvld_d  = 1'b1;
			rdata_d = 8'h00;
			if (port_hit) begin
				unique case (ofs)
					`PACL_OFS_ACL_CTRL: begin
						rdata_d = acl_access_trigger_ctrl_q;
					end
					`PACL_OFS_MIRROR: begin
						rdata_d = port_mirror_ctrl_q;
					end
					`PACL_OFS_PRIO: begin
						rdata_d = port_prio_class_ctrl_q;
					end
					default: begin
						rdata_d = 8'h00;
					end
				endcase
			end
		end
	end

	// Read answer flip-flops
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= 8'h00;
			rvld_q  <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			rvld_q  <= rvld_d;
		end
	end

	// Frame marks and priority result
	always_comb begin
		// Received frame monitored and copied to the sniffer
		rx_mon_d = rx_frame_i
			&& port_mirror_ctrl_q[`PACL_BIT_RX_SNIFF];
		// Transmitted frame monitored and copied to the sniffer
		tx_mon_d = tx_frame_i
			&& port_mirror_ctrl_q[`PACL_BIT_TX_SNIFF];
		// Only the sniffer port sends monitored copies
		mon_tx_d = mon_frame_i
			&& port_mirror_ctrl_q[`PACL_BIT_SNIFFER];
		prio_d     = prio_q;
		prio_hit_d = prio_hit_q;
		prio_vld_d = cls_vld_i;
		// Capture the resolved priority per classified frame
		if (cls_vld_i) begin
			prio_d     = res_prio;
			prio_hit_d = res_hit;
		end
	end

	// Frame mark and priority flip-flops
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_mon_q   <= 1'b0;
			tx_mon_q   <= 1'b0;
			mon_tx_q   <= 1'b0;
			prio_q     <= `PACL_RST_PRIO_OUT;
			prio_vld_q <= 1'b0;
			prio_hit_q <= 1'b0;
		end else begin
			rx_mon_q   <= rx_mon_d;
			tx_mon_q   <= tx_mon_d;
			mon_tx_q   <= mon_tx_d;
			prio_q     <= prio_d;
			prio_vld_q <= prio_vld_d;
			prio_hit_q <= prio_hit_d;
		end
	end

	// Outputs, all from flip-flops
	assign reg_rdata_o = rdata_q;
	assign reg_rvld_o  = rvld_q;
	assign tbl_req_o   = tbl_req_q;
	assign rx_mon_o    = rx_mon_q;
	assign tx_mon_o    = tx_mon_q;
	assign mon_tx_o    = mon_tx_q;
	assign rx_sniff_o  = port_mirror_ctrl_q[`PACL_BIT_RX_SNIFF];
	assign tx_sniff_o  = port_mirror_ctrl_q[`PACL_BIT_TX_SNIFF];
	assign sniffer_o   = port_mirror_ctrl_q[`PACL_BIT_SNIFFER];
	assign prio_o      = prio_q;
	assign prio_vld_o  = prio_vld_q;
	assign prio_hit_o  = prio_hit_q;

endmodule

// File: logic/pacl_prio_resolve.sv
// Combines enabled classification results into one ingress priority.
// Assumes results and controls are stable in the cycle they are read.
`timescale 1ns/1ps
`include "pacl_params.svh"

module pacl_prio_resolve
	import pacl_pkg::*;
(
	// Controls and inputs
	input  wire logic [7:0] ctrl_i,
	input  wire pacl_cls_t  cls_i,
	input  wire logic [2:0] dflt_i,
	// Result
	output logic      [2:0] prio_o,
	output logic            hit_o
);

	// Results gathered in control bit order
	logic [4:0][2:0] src;
	// Sources both enabled and delivering a result
	logic [4:0]      en;

	// Place each result at the index of its enable bit
	always_comb begin
		src[`PACL_BIT_MAC_EN]  = cls_i.mac;
		src[`PACL_BIT_VLAN_EN] = cls_i.vlan;
		src[`PACL_BIT_PCP_EN]  = cls_i.pcp;
		src[`PACL_BIT_DSCP_EN] = cls_i.dscp;
		src[`PACL_BIT_ACL_EN]  = cls_i.acl;
		en = ctrl_i[4:0] & cls_i.vld;
	end

	// Highest, OR of all, or first found starting at the list source
	always_comb begin
		logic [2:0] hi;
		logic [2:0] orv;
		logic [2:0] first;
		logic       found;
		hi    = 3'h0;
		orv   = 3'h0;
		first = 3'h0;
		found = 1'b0;
		for (int i = 0; i < 5; i++) begin
			if (en[i]) begin
				if (src[i] > hi) begin
					hi = src[i];
				end
				orv = orv | src[i];
				if (!found) begin
					first = src[i];
					found = 1'b1;
				end
			end
		end
		hit_o = found;
		// No enabled source: port default priority
		if (!found) begin
			prio_o = dflt_i;
		end else if (ctrl_i[`PACL_BIT_HIGHEST]) begin
			prio_o = hi;
		end else if (ctrl_i[`PACL_BIT_ORED]) begin
			prio_o = orv;
		end else begin
			prio_o = first;
		end
	end

endmodule
